// ### i2c_gpio_pkg.sv
// Constants, states and encodings of the serial-bus 16-bit I/O expander.
// Assumes a single core clock domain; all pins are synchronised in the top.
package i2c_gpio_pkg;
  // Pair codes in command bits [2:1]
  localparam logic [1:0] PAIR_IN = 2'h0;
  localparam logic [1:0] PAIR_OUT = 2'h1;
  localparam logic [1:0] PAIR_POL = 2'h2;
  localparam logic [1:0] PAIR_CFG = 2'h3;
  // Values after reset
  localparam logic [15:0] OUT_RST = 16'hffff;
  localparam logic [15:0] POL_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'hffff;
  localparam logic [2:0] PTR_RST = 3'h0;
  // Bits per byte on the wire
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Default FIFO depth in the write path
  localparam int FIFO_DEPTH_DEF = 4;
  localparam int FIFO_WIDTH = 11;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_AACK = 4'h2,
    ST_CMD = 4'h3,
    ST_CACK = 4'h4,
    ST_WDAT = 4'h5,
    ST_WACK = 4'h6,
    ST_RDAT = 4'h7,
    ST_RACK = 4'h8,
    ST_SKIP = 4'h9
  } i2c_state_e;
endpackage : i2c_gpio_pkg

// ### i2c_gpio_expander.sv
// Serial-bus target with a four-pair register file and change interrupt.
// Assumes scl/sda and GPIO pins are asynchronous; clk is much faster than scl.

////////////////////////////////////////////////////////////////////////////////
// Small FIFO between the byte receiver and the register file
module gpio_byte_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two of at least two");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic do_wr;
  logic do_rd;

  // Honest full and empty from the fill count
  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rd_r];
  assign do_wr = ce && in_valid && in_ready;
  assign do_rd = ce && out_valid && out_ready;

  // Storage has no reset; only valid entries are ever read
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_r] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_wr) begin
        wr_r <= wr_r + 1'b1;
      end
      if (do_rd) begin
        rd_r <= rd_r + 1'b1;
      end
      if (do_wr && !do_rd) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule : gpio_byte_fifo

////////////////////////////////////////////////////////////////////////////////
// Top of the expander
module i2c_gpio_expander #(
  parameter logic [3:0] ADDR_PREFIX = 4'h4,
  parameter int FIFO_DEPTH = i2c_gpio_pkg::FIFO_DEPTH_DEF
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // Supply monitor: high once supply is at or above the power-on threshold
  input wire logic power_on_threshold,
  // Serial bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Address select straps
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit2,
  // Port pins, bits 7:0 port 0, bits 15:8 port 1
  input wire logic [15:0] gpio_i,
  output logic [15:0] gpio_o,
  output logic [15:0] gpio_oe_n,
  // Open-drain interrupt
  output logic int_o,
  output logic int_oe_n
);
  localparam int SW = 22;
  localparam int W = i2c_gpio_pkg::FIFO_WIDTH;

  generate
    if (FIFO_DEPTH < 2) begin : g_bad_param
      $error("FIFO_DEPTH below two cannot buffer writes");
    end
  endgenerate

  i2c_gpio_pkg::i2c_state_e state_r, state_nxt;
  logic [SW-1:0] s1_r, s2_r;
  logic scl_s, sda_s, por_s, scl_d_r, sda_d_r;
  logic [2:0] sel_s;
  logic [15:0] pin_s;
  logic hold, go, scl_rise, scl_fall, start, stop;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] rx_r, tx_r, tx_nxt, rd_val;
  logic [2:0] ptr_r;
  logic [15:0] out_r, pol_r, cfg_r, snap_r;
  logic init_r, rw_r, mack_r, sda_oe_n_r, int_oe_n_r;
  logic drv_nxt, push, load_rd, match, pend;
  logic f_ready, d_valid, d_ready;
  logic [W-1:0] d_data;

  //////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for every asynchronous input
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= '0;
      s2_r <= '0;
    end else if (ce) begin
      s1_r <= {power_on_threshold, scl_i, sda_i, addr_select_bit2,
               addr_select_bit1, addr_select_bit0, gpio_i};
      s2_r <= s1_r;
    end
  end

  assign por_s = s2_r[21];
  assign scl_s = s2_r[20];
  assign sda_s = s2_r[19];
  assign sel_s = s2_r[18:16];
  assign pin_s = s2_r[15:0];
  // Supply below threshold keeps everything at defaults
  assign hold = !por_s;
  assign go = ce && !hold;

  // Delayed copies for edge and condition detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else if (ce) begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign match = rx_r[7:1] == {ADDR_PREFIX, sel_s};

  //////////////////////////////////////////////////////////////////////////////
  // Read data selection by pair and port
  function automatic logic [7:0] pick(input logic [15:0] v, input logic hi);
    pick = hi ? v[15:8] : v[7:0];
  endfunction : pick

  // Live pins go out for input reads, so the snapshot and the byte agree
  always_comb begin
    case (ptr_r[2:1])
      i2c_gpio_pkg::PAIR_IN: rd_val = pick(pin_s ^ pol_r, ptr_r[0]);
      i2c_gpio_pkg::PAIR_OUT: rd_val = pick(out_r, ptr_r[0]);
      i2c_gpio_pkg::PAIR_POL: rd_val = pick(pol_r, ptr_r[0]);
      default: rd_val = pick(cfg_r, ptr_r[0]);
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus machine next state; drive decided here so sda moves right after scl falls
  always_comb begin
    state_nxt = state_r;
    bit_nxt = bit_r;
    tx_nxt = tx_r;
    push = 1'b0;
    load_rd = 1'b0;
    if (start) begin
      state_nxt = i2c_gpio_pkg::ST_ADDR;
      bit_nxt = '0;
    end else if (stop) begin
      state_nxt = i2c_gpio_pkg::ST_IDLE;
    end else if (scl_rise) begin
      if (state_r inside {i2c_gpio_pkg::ST_ADDR, i2c_gpio_pkg::ST_CMD,
                          i2c_gpio_pkg::ST_WDAT, i2c_gpio_pkg::ST_RDAT}) begin
        bit_nxt = bit_r + 1'b1;
      end
    end else if (scl_fall) begin
      case (state_r)
        i2c_gpio_pkg::ST_ADDR: begin
          if (bit_r == i2c_gpio_pkg::BYTE_BITS) begin
            state_nxt = match ? i2c_gpio_pkg::ST_AACK : i2c_gpio_pkg::ST_SKIP;
          end
        end
        i2c_gpio_pkg::ST_AACK: begin
          bit_nxt = '0;
          if (rw_r) begin
            state_nxt = i2c_gpio_pkg::ST_RDAT;
            tx_nxt = rd_val;
            load_rd = 1'b1;
          end else begin
            state_nxt = i2c_gpio_pkg::ST_CMD;
          end
        end
        i2c_gpio_pkg::ST_CMD: begin
          if (bit_r == i2c_gpio_pkg::BYTE_BITS) begin
            state_nxt = i2c_gpio_pkg::ST_CACK;
          end
        end
        i2c_gpio_pkg::ST_CACK, i2c_gpio_pkg::ST_WACK: begin
          bit_nxt = '0;
          state_nxt = i2c_gpio_pkg::ST_WDAT;
        end
        i2c_gpio_pkg::ST_WDAT: begin
          if (bit_r == i2c_gpio_pkg::BYTE_BITS) begin
            // A full FIFO turns into a refusal on the wire, not a lost byte
            push = f_ready;
            state_nxt = f_ready ? i2c_gpio_pkg::ST_WACK : i2c_gpio_pkg::ST_SKIP;
          end
        end
        i2c_gpio_pkg::ST_RDAT: begin
          if (bit_r == i2c_gpio_pkg::BYTE_BITS) begin
            state_nxt = i2c_gpio_pkg::ST_RACK;
          end else begin
            tx_nxt = {tx_r[6:0], 1'b1};
          end
        end
        i2c_gpio_pkg::ST_RACK: begin
          bit_nxt = '0;
          if (mack_r) begin
            state_nxt = i2c_gpio_pkg::ST_RDAT;
            tx_nxt = rd_val;
            load_rd = 1'b1;
          end else begin
            state_nxt = i2c_gpio_pkg::ST_SKIP;
          end
        end
        default: state_nxt = state_r;
      endcase
    end
    drv_nxt = (state_nxt inside {i2c_gpio_pkg::ST_AACK, i2c_gpio_pkg::ST_CACK,
                                 i2c_gpio_pkg::ST_WACK}) ||
              (state_nxt == i2c_gpio_pkg::ST_RDAT && !tx_nxt[7]);
  end

  // Bus machine registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= i2c_gpio_pkg::ST_IDLE;
      bit_r <= '0;
      tx_r <= '1;
      sda_oe_n_r <= 1'b1;
    end else if (ce) begin
      if (hold) begin
        state_r <= i2c_gpio_pkg::ST_IDLE;
        bit_r <= '0;
        tx_r <= '1;
        sda_oe_n_r <= 1'b1;
      end else begin
        state_r <= state_nxt;
        bit_r <= bit_nxt;
        tx_r <= tx_nxt;
        sda_oe_n_r <= !drv_nxt;
      end
    end
  end

  // Receive shifter, direction bit and master acknowledge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_r <= '0;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
    end else if (ce && hold) begin
      rx_r <= '0;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
    end else if (go && scl_rise) begin
      if (state_r inside {i2c_gpio_pkg::ST_ADDR, i2c_gpio_pkg::ST_CMD,
                          i2c_gpio_pkg::ST_WDAT}) begin
        rx_r <= {rx_r[6:0], sda_s};
      end
      if (state_r == i2c_gpio_pkg::ST_AACK) begin
        rw_r <= rx_r[0];
      end
      if (state_r == i2c_gpio_pkg::ST_RACK) begin
        mack_r <= !sda_s;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register pointer: loaded by the command, flipped after each byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_r <= i2c_gpio_pkg::PTR_RST;
    end else if (ce) begin
      if (hold) begin
        ptr_r <= i2c_gpio_pkg::PTR_RST;
      end else if (scl_fall && state_r == i2c_gpio_pkg::ST_CACK) begin
        ptr_r <= rx_r[2:0];
      end else if (push || load_rd) begin
        ptr_r <= ptr_r ^ 3'h1;
      end
    end
  end

  // Written bytes queue with their target index
  gpio_byte_fifo #(
    .WIDTH(W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .in_valid(push && !hold),
    .in_ready(f_ready),
    .in_data({ptr_r, rx_r}),
    .out_valid(d_valid),
    .out_ready(d_ready),
    .out_data(d_data)
  );

  // Drain pauses while a read loads, so a read never races a register update;
  // under hold it empties and the register file drops what comes out
  assign d_ready = hold || !load_rd;

  // Register file writes from the FIFO
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_r <= i2c_gpio_pkg::OUT_RST;
      pol_r <= i2c_gpio_pkg::POL_RST;
      cfg_r <= i2c_gpio_pkg::CFG_RST;
    end else if (ce) begin
      if (hold) begin
        out_r <= i2c_gpio_pkg::OUT_RST;
        pol_r <= i2c_gpio_pkg::POL_RST;
        cfg_r <= i2c_gpio_pkg::CFG_RST;
      end else if (d_valid && d_ready) begin
        case (d_data[10:9])
          i2c_gpio_pkg::PAIR_OUT: begin
            if (d_data[8]) out_r[15:8] <= d_data[7:0];
            else out_r[7:0] <= d_data[7:0];
          end
          i2c_gpio_pkg::PAIR_POL: begin
            if (d_data[8]) pol_r[15:8] <= d_data[7:0];
            else pol_r[7:0] <= d_data[7:0];
          end
          i2c_gpio_pkg::PAIR_CFG: begin
            if (d_data[8]) cfg_r[15:8] <= d_data[7:0];
            else cfg_r[7:0] <= d_data[7:0];
          end
          default: out_r <= out_r;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Input snapshot: taken once after reset, then per port at read acknowledge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      snap_r <= '0;
      init_r <= 1'b0;
    end else if (ce) begin
      if (hold) begin
        init_r <= 1'b0;
      end else if (!init_r) begin
        snap_r <= pin_s;
        init_r <= 1'b1;
      end else if (load_rd && ptr_r[2:1] == i2c_gpio_pkg::PAIR_IN) begin
        if (ptr_r[0]) snap_r[15:8] <= pin_s[15:8];
        else snap_r[7:0] <= pin_s[7:0];
      end
    end
  end

  // Any input pin away from its snapshot keeps the line low
  assign pend = init_r && |((pin_s ^ snap_r) & cfg_r);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_oe_n_r <= 1'b1;
    end else if (ce) begin
      int_oe_n_r <= !pend;
    end
  end

  assign sda_o = 1'b0;
  assign int_o = 1'b0;
  assign sda_oe_n = sda_oe_n_r;
  assign int_oe_n = int_oe_n_r;
  assign gpio_o = out_r;
  assign gpio_oe_n = cfg_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_addr_done;
    go && !start && !stop && scl_fall && state_r == i2c_gpio_pkg::ST_ADDR &&
      bit_r == i2c_gpio_pkg::BYTE_BITS;
  endsequence

  hold_defaults_a: assert property (ce && hold |=> state_r == i2c_gpio_pkg::ST_IDLE &&
    cfg_r == i2c_gpio_pkg::CFG_RST && out_r == i2c_gpio_pkg::OUT_RST && sda_oe_n_r)
    else $error("defaults not restored under hold");
  addr_ack_a: assert property (s_addr_done ##0 match |=> !sda_oe_n_r [*1] ##0
    state_r == i2c_gpio_pkg::ST_AACK)
    else $error("own address not acknowledged");
  addr_miss_a: assert property (s_addr_done ##0 !match |=> sda_oe_n_r &&
    state_r == i2c_gpio_pkg::ST_SKIP)
    else $error("foreign address answered");
  cmd_ptr_a: assert property (go && !start && !stop && scl_fall &&
    state_r == i2c_gpio_pkg::ST_CACK |=> ptr_r == $past(rx_r[2:0]))
    else $error("command did not load pointer");
  wr_toggle_a: assert property (go && push |=> ptr_r == ($past(ptr_r) ^ 3'h1))
    else $error("pointer did not flip after write");
  rd_load_a: assert property (go && load_rd |=> tx_r == $past(rd_val) &&
    ptr_r == ($past(ptr_r) ^ 3'h1))
    else $error("read byte or pointer wrong");
  in_ignore_a: assert property (go && d_valid && d_ready &&
    d_data[10:9] == i2c_gpio_pkg::PAIR_IN |=> $stable(out_r) && $stable(pol_r) &&
    $stable(cfg_r))
    else $error("input port write changed a register");
  int_level_a: assert property (ce ##1 ce |-> int_oe_n_r == !$past(pend))
    else $error("interrupt line not following pending state");
  out_no_int_a: assert property (ce && ((pin_s ^ snap_r) & ~cfg_r) != '0 &&
    ((pin_s ^ snap_r) & cfg_r) == '0 |=> int_oe_n_r)
    else $error("output pin raised interrupt");
  stop_idle_a: assert property (go && stop |=> state_r == i2c_gpio_pkg::ST_IDLE &&
    sda_oe_n_r)
    else $error("stop did not return to idle");
  rack_release_a: assert property (state_r == i2c_gpio_pkg::ST_RACK |-> sda_oe_n_r)
    else $error("data line held during master acknowledge");
endmodule : i2c_gpio_expander

// ### i2c_master_model.sv
// Behavioural bus master that drives the expander's serial clock and data.
// Assumes a pull-up on the data wire; the bench resolves the wire level.
module i2c_master_model (
  // Pace reference
  input wire logic clk,
  input wire logic slow,
  // Bus lines
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus: clock parked high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quarter bit of 20 ns, doubled when slowed to stretch every phase
  task automatic q();
    repeat (slow ? 4 : 2) @(negedge clk);
  endtask : q

  // Start or repeated start; the data fall lands with the clock high
  task automatic start();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask : start

  // Stop may follow any bit, even in mid-byte
  task automatic stop();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask : stop

  // One bit; data changes only while the clock is low
  task automatic bitx(input logic b, output logic r);
    sda_low = ~b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask : bitx

  // Byte out, most significant bit first, then the target's answer
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'b1, r);
    ack = ~r;
  endtask : wbyte

  // Byte in; the last byte is answered with a release
  task automatic rbyte(input logic ack, output logic [7:0] d, output logic r9);
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, d[i]);
    end
    bitx(~ack, r9);
  endtask : rbyte
endmodule : i2c_master_model

// ### tb_i2c_gpio_expander_port_logic.sv
// Self-checking bench for the serial-bus I/O expander.
// Assumes the default address prefix and a 100 MHz core clock.
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_i2c_gpio_expander_port_logic;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] ADR = 7'h25;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic power_on_threshold = 1'b1;
  logic slow = 1'b0;
  logic [15:0] pins = 16'h3ca5;
  logic scl, m_low, sda_o, sda_oe_n, int_o, int_oe_n, ak, r9;
  logic [15:0] gpio_o, gpio_oe_n;
  logic [7:0] rb0, rb1;
  wire sda_w;
  wire [15:0] pin_w;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;

  // Wires: pull-up on data, driven pins win over the outside world
  assign sda_w = ~(m_low | (~sda_oe_n & ~sda_o));
  assign pin_w = (~gpio_oe_n & gpio_o) | (gpio_oe_n & pins);
  always #5 clk = ~clk;

  i2c_master_model m (.clk(clk), .slow(slow), .scl(scl), .sda_low(m_low), .sda(sda_w));
  i2c_gpio_expander u_dut (
    .clk(clk), .arst_n(arst_n), .ce(1'b1), .power_on_threshold(power_on_threshold),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .addr_select_bit0(1'b1), .addr_select_bit1(1'b0), .addr_select_bit2(1'b1),
    .gpio_i(pin_w), .gpio_o(gpio_o), .gpio_oe_n(gpio_oe_n), .int_o(int_o),
    .int_oe_n(int_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Verdict; also the landing place of the hang guard
  task automatic wrap_up();
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // Hang guard well above the roughly ten thousand cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic wb(input logic [7:0] d);
    m.wbyte(d, ak);
    `CHK("ack", 1'b1, ak)
  endtask : wb

  // Three data bytes, so the pointer ends on the other register of the pair and the first register is written twice
  task automatic wr(input logic [7:0] c, input logic [7:0] d0, d1, d2);
    m.start();
    wb({ADR, 1'b0});
    wb(c);
    wb(d0);
    wb(d1);
    wb(d2);
    m.stop();
  endtask : wr

  // Command write, repeated start, then one or two bytes back
  task automatic rd(input logic [7:0] c, input int n);
    m.start();
    wb({ADR, 1'b0});
    wb(c);
    m.start();
    wb({ADR, 1'b1});
    m.rbyte(n > 1, rb0, r9);
    if (n > 1) begin
      m.rbyte(1'b0, rb1, r9);
    end
    `CHK("release", 1'b1, r9)
    m.stop();
  endtask : rd

  task automatic settle();
    repeat (8) @(negedge clk);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  // Every command code against its register's reset content
  task automatic t_defaults();
    logic [7:0] exp [8];
    exp = '{8'ha5, 8'h3c, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
    for (int c = 0; c < 8; c++) begin
      rd(c[7:0], 1);
      `CHK("reg", exp[c], rb0)
    end
    `CHK("dir", 16'hffff, gpio_oe_n)
    `CHK("int", 1'b1, int_oe_n)
  endtask : t_defaults

  task automatic t_write();
    wr(8'h03, 8'ha5, 8'h3c, 8'h96);
    `CHK("out", 16'h963c, gpio_o)
    rd(8'h02, 2);
    `CHK("rd0", 8'h3c, rb0)
    `CHK("rd1", 8'h96, rb1)
  endtask : t_write

  // Slow pace here so both bus speeds are exercised
  task automatic t_pol();
    slow = 1'b1;
    wr(8'h04, 8'h0f, 8'hf0, 8'h0f);
    rd(8'h00, 2);
    `CHK("pol0", 8'haa, rb0)
    `CHK("pol1", 8'hcc, rb1)
    wr(8'h00, 8'h00, 8'h00, 8'h00);
    rd(8'h00, 1);
    `CHK("in ro", 8'haa, rb0)
    wr(8'h04, 8'h00, 8'h00, 8'h00);
    slow = 1'b0;
  endtask : t_pol

  // Pin 3 starts low, so raising it is the change
  task automatic t_int();
    pins[3] = 1'b1;
    settle();
    `CHK("int set", 1'b0, int_oe_n)
    `CHK("int drv", 1'b0, int_o)
    pins[3] = 1'b0;
    settle();
    `CHK("int back", 1'b1, int_oe_n)
    pins[2] = 1'b0;
    pins[9] = 1'b1;
    settle();
    rd(8'h01, 1);
    `CHK("int p0", 1'b0, int_oe_n)
    rd(8'h00, 1);
    `CHK("int clr", 1'b1, int_oe_n)
  endtask : t_int

  // Port 0 turned to outputs flips its pin levels, yet no interrupt
  task automatic t_out();
    wr(8'h06, 8'h00, 8'hff, 8'h00);
    `CHK("dir out", 16'hff00, gpio_oe_n)
    settle();
    `CHK("no int", 1'b1, int_oe_n)
    wr(8'h06, 8'hff, 8'hff, 8'hff);
    rd(8'h00, 2);
  endtask : t_out

  task automatic t_addr_stop();
    m.start();
    m.wbyte({7'h24, 1'b0}, ak);
    `CHK("foreign", 1'b0, ak)
    m.stop();
    m.start();
    wb({ADR, 1'b0});
    wb(8'h02);
    for (int i = 0; i < 4; i++) begin
      m.bitx(1'b0, r9);
    end
    m.stop();
    `CHK("cut", 16'h963c, gpio_o)
    rd(8'h03, 1);
    `CHK("after", 8'h96, rb0)
  endtask : t_addr_stop

  task automatic t_por();
    wr(8'h02, 8'h11, 8'h22, 8'h11);
    power_on_threshold = 1'b0;
    settle();
    `CHK("held", 16'hffff, gpio_o)
    power_on_threshold = 1'b1;
    repeat (10) @(negedge clk);
    rd(8'h02, 2);
    `CHK("def0", 8'hff, rb0)
    `CHK("def1", 8'hff, rb1)
  endtask : t_por

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    repeat (10) @(negedge clk);
    t_defaults();
    t_write();
    t_pol();
    t_int();
    t_out();
    t_addr_stop();
    t_por();
    wrap_up();
  end
endmodule : tb_i2c_gpio_expander_port_logic
